// ---- pkg/btm_pkg.sv ----
// Package with register map, field layout and types for the bus transceiver mode registers.
`default_nettype none
package btm_pkg;
	localparam logic [6:0] AddrBusA     = 7'h04;
	localparam logic [6:0] AddrBusB     = 7'h05;
	localparam logic [7:0] ResetBusA    = 8'h20;
	localparam logic [7:0] ResetBusB    = 8'h00;
	localparam logic [7:0] MaskBusB     = 8'h23;
	localparam logic [4:0] FailSafeLow  = 5'h09;
	localparam logic [1:0] ModeOff      = 2'h0;
	localparam logic [1:0] ModeWake     = 2'h1;
	localparam logic [1:0] ModeRxOnly   = 2'h2;
	localparam logic [1:0] ModeNormal   = 2'h3;
	localparam int         BitFlash     = 7;
	localparam int         BitLowSlope  = 6;
	localparam int         BitTxTimeout = 5;
	localparam int         BitPeakTh    = 5;

	typedef enum logic [2:0] {
		SbcInit     = 3'h0,
		SbcNormal   = 3'h1,
		SbcStop     = 3'h3,
		SbcSleep    = 3'h2,
		SbcRestart  = 3'h6,
		SbcFailSafe = 3'h7
	} btm_sbc_mode_t;

	typedef struct packed {
		logic       linFlash;
		logic       linLowSlopeSel;
		logic       linTxTimeoutEn;
		logic [1:0] linMode;
		logic       selectiveWake;
		logic [1:0] canMode;
	} btm_bus_a_t;

	typedef struct packed {
		logic       regulatorPeakThresholdSel;
		logic [1:0] secondLinMode;
	} btm_bus_b_t;

	typedef struct packed {
		logic       linFlash;
		logic       linLowSlopeSel;
		logic       linTxTimeoutEn;
		logic [1:0] linMode;
		logic       selectiveWake;
		logic [1:0] canMode;
		logic [1:0] secondLinMode;
		logic       regulatorPeakThresholdSel;
	} btm_xcvr_cfg_t;

	typedef struct packed {
		logic       wr;
		logic [6:0] addr;
		logic [7:0] data;
	} btm_access_t;
endpackage
`default_nettype wire

// ---- core/btm_sync.sv ----
// Three-stage synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/1ps
`default_nettype none
module btm_sync (
	input  wire logic mclk,
	input  wire logic resetn,
	input  wire logic clkEn,
	input  wire logic din,
	output var  logic dout
);
	import btm_pkg::*;

	typedef struct packed {
		logic [2:0] stage;
		logic       level;
	} btm_sync_state_t;

	btm_sync_state_t s_q;
	btm_sync_state_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.stage = {s_q.stage[1:0], din};
		if (s_q.stage[1] == s_q.stage[2]) begin
			s_d.level = s_q.stage[2];
		end
	end

	// Reset value is high because the input is an idle-high chip select.
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			s_q <= '{stage: 3'h7, level: 1'b1};
		end else if (clkEn) begin
			s_q <= s_d;
		end
	end

	assign dout = s_q.level;
endmodule
`default_nettype wire

// ---- core/btm_mode_ctrl.sv ----
// Automatic rewrite of the CAN and first LIN mode fields on SBC mode entry.
`timescale 1ns/1ps
`default_nettype none
module btm_mode_ctrl (
	input  wire logic                    sysErrorEnable,
	input  wire btm_pkg::btm_sbc_mode_t  modeEntry,
	input  wire logic                    entryValid,
	input  wire btm_pkg::btm_bus_a_t     cur,
	output var  btm_pkg::btm_bus_a_t     nxt
);
	import btm_pkg::*;

	always_comb begin
		nxt = cur;
		if (entryValid) begin
			case (modeEntry)
				SbcSleep: begin
					if (cur.canMode == ModeNormal && !sysErrorEnable) begin
						nxt.canMode = ModeWake;
					end else if (cur.canMode == ModeRxOnly) begin
						nxt.canMode = ModeWake;
					end
				end
				SbcStop: begin
					nxt.canMode = cur.canMode;
				end
				SbcFailSafe: begin
					// The top three configuration bits are kept; only the low five are forced.
					{nxt.linMode, nxt.selectiveWake, nxt.canMode} = FailSafeLow;
				end
				default: begin
					nxt = cur;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- core/btm_regs.sv ----
// Bus transceiver mode register bank with host access and automatic mode updates.
`timescale 1ns/1ps
`default_nettype none
module btm_regs (
	input  wire logic                   mclk,
	input  wire logic                   resetn,
	input  wire logic                   clkEn,
	input  wire logic                   softReset,
	input  wire logic                   restart,
	input  wire btm_pkg::btm_access_t   access,
	input  wire logic                   accessValid,
	input  wire logic                   chipSelectN,
	input  wire btm_pkg::btm_sbc_mode_t sbcMode,
	input  wire logic                   modeEntry,
	input  wire logic                   systemErrorEnable,
	input  wire logic                   intGlobal,
	input  wire logic                   statusEvent,
	input  wire logic                   wakeEvent,
	input  wire logic [1:0]             restartLinMode,
	input  wire logic [1:0]             restartCanMode,
	input  wire logic [1:0]             restartSecondLinMode,
	output var  logic [7:0]             readData,
	output var  logic                   spiFail,
	output var  logic                   intReq,
	output var  btm_pkg::btm_xcvr_cfg_t xcvrCfg
);
	import btm_pkg::*;

	typedef struct packed {
		btm_bus_a_t     busA;
		btm_bus_b_t     busB;
		logic           pendFlash;
		logic           pendLowSlope;
		logic [7:0]     rdata;
		logic           fail;
		logic           irq;
		btm_xcvr_cfg_t  cfg;
	} btm_regs_state_t;

	btm_regs_state_t s_q;
	btm_regs_state_t s_d;
	btm_bus_a_t      autoA;
	logic            chip_select_n;
	logic            csNPrev;

	function automatic logic [7:0] readB(input btm_bus_b_t b);
		readB = 8'h00;
		readB[BitPeakTh] = b.regulatorPeakThresholdSel;
		readB[1:0] = b.secondLinMode;
		readB = readB & MaskBusB;
	endfunction

	btm_sync u_csSync (
		.mclk   (mclk),
		.resetn (resetn),
		.clkEn  (clkEn),
		.din    (chipSelectN),
		.dout   (chip_select_n)
	);

	btm_mode_ctrl u_modeCtrl (
		.sysErrorEnable (systemErrorEnable),
		.modeEntry      (sbcMode),
		.entryValid     (modeEntry),
		.cur            (s_q.busA),
		.nxt            (autoA)
	);

	// ==========================================================
	// Next state.
	always_comb begin
		s_d = s_q;
		s_d.busA = autoA;
		s_d.fail = 1'b0;
		if (modeEntry && sbcMode == SbcFailSafe) begin
			s_d.busB.secondLinMode = ModeWake;
		end
		if (accessValid && access.wr && !modeEntry) begin
			if (access.addr == AddrBusA) begin
				s_d.busA = btm_bus_a_t'(access.data);
				s_d.busA.linFlash = s_q.busA.linFlash;
				s_d.busA.linLowSlopeSel = s_q.busA.linLowSlopeSel;
				s_d.pendFlash = access.data[BitFlash];
				s_d.pendLowSlope = access.data[BitLowSlope];
			end else if (access.addr == AddrBusB) begin
				s_d.busB.secondLinMode = access.data[1:0];
				if (sbcMode == SbcInit || sbcMode == SbcNormal) begin
					s_d.busB.regulatorPeakThresholdSel = access.data[BitPeakTh];
				end
			end
		end
		if (chip_select_n && !csNPrev) begin
			s_d.busA.linFlash = s_q.pendFlash;
			s_d.busA.linLowSlopeSel = s_q.pendLowSlope;
		end
		if (restart) begin
			s_d.busA = s_q.busA;
			s_d.busA.linMode = restartLinMode;
			s_d.busA.canMode = restartCanMode;
			s_d.busB.secondLinMode = restartSecondLinMode;
		end
		if (accessValid && !access.wr) begin
			case (access.addr)
				AddrBusA: s_d.rdata = 8'(s_q.busA);
				AddrBusB: s_d.rdata = readB(s_q.busB);
				default: s_d.rdata = 8'h00;
			endcase
		end
		s_d.irq = statusEvent && intGlobal || wakeEvent;
		s_d.cfg = '{linFlash: s_d.busA.linFlash, linLowSlopeSel: s_d.busA.linLowSlopeSel,
			linTxTimeoutEn: s_d.busA.linTxTimeoutEn, linMode: s_d.busA.linMode,
			selectiveWake: s_d.busA.selectiveWake, canMode: s_d.busA.canMode,
			secondLinMode: s_d.busB.secondLinMode,
			regulatorPeakThresholdSel: s_d.busB.regulatorPeakThresholdSel};
	end

	// ==========================================================
	// State registers.
	always_ff @(posedge mclk) begin
		if (!resetn || (softReset && clkEn)) begin
			s_q <= '{busA: btm_bus_a_t'(ResetBusA), busB: '0, pendFlash: 1'b0,
				pendLowSlope: 1'b0, rdata: 8'h00, fail: 1'b0, irq: 1'b0,
				cfg: btm_xcvr_cfg_t'({ResetBusA, 3'h0})};
			csNPrev <= 1'b1;
		end else if (clkEn) begin
			s_q <= s_d;
			csNPrev <= chip_select_n;
		end
	end

	assign readData = s_q.rdata;
	assign spiFail  = s_q.fail;
	assign intReq   = s_q.irq;
	assign xcvrCfg  = s_q.cfg;
endmodule
`default_nettype wire

// ---- tb/btm_regs_asserts.sv ----
// Concurrent checks on the ports of the mode register bank.
`timescale 1ns/1ps
`default_nettype none
module btm_regs_asserts (
	input wire logic mclk, resetn, softReset, restart, accessValid, chipSelectN,
	input wire logic modeEntry, systemErrorEnable, intGlobal, statusEvent, wakeEvent,
	input wire btm_pkg::btm_access_t access,
	input wire btm_pkg::btm_sbc_mode_t sbcMode,
	input wire logic [7:0] readData,
	input wire logic spiFail, intReq,
	input wire btm_pkg::btm_xcvr_cfg_t xcvrCfg
);
	import btm_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	wire wr = accessValid && access.wr;
	wire ent = modeEntry && !softReset && !restart;
	wire [1:0] can = xcvrCfg.canMode;
	wire sls = sbcMode inside {SbcSleep, SbcStop};
	property p_resB;
		accessValid && !access.wr && access.addr == AddrBusB |=> (readData & ~MaskBusB) == 8'h00;
	endproperty
	a_resB: assert property (p_resB) else $error("reserved bits set");
	property p_fail;
		ent && sbcMode == SbcFailSafe |=> xcvrCfg[7:3] == FailSafeLow;
	endproperty
	a_fail: assert property (p_fail) else $error("fail-safe value wrong");
	property p_norm;
		ent && sbcMode == SbcSleep && !systemErrorEnable && can == ModeNormal |=> can == ModeWake;
	endproperty
	a_norm: assert property (p_norm) else $error("normal not turned to wake");
	property p_rx;
		ent && can == ModeRxOnly && sls |=>
			can == ($past(sbcMode) == SbcSleep ? ModeWake : ModeRxOnly);
	endproperty
	a_rx: assert property (p_rx) else $error("receive only handled wrong");
	property p_keep;
		ent && can <= ModeWake && sls |=> $stable(can);
	endproperty
	a_keep: assert property (p_keep) else $error("wake or off changed");
	property p_swk;
		!softReset && !restart && !(modeEntry && sbcMode == SbcFailSafe)
			&& !(wr && access.addr == AddrBusA) |=> $stable(xcvrCfg.selectiveWake);
	endproperty
	a_swk: assert property (p_swk) else $error("selective wake changed");
	property p_slope;
		(!chipSelectN && !softReset && !restart)[*6] |-> $stable(xcvrCfg[10:9]);
	endproperty
	a_slope: assert property (p_slope) else $error("slope changed in frame");
	property p_int;
		statusEvent || wakeEvent |=> intReq == $past(wakeEvent || (intGlobal && statusEvent));
	endproperty
	a_int: assert property (p_int) else $error("interrupt wrong");
	property p_peak;
		wr && access.addr == AddrBusB && sbcMode == SbcStop && !softReset && !restart
			|=> !spiFail && $stable(xcvrCfg.regulatorPeakThresholdSel);
	endproperty
	a_peak: assert property (p_peak) else $error("peak bit changed in stop");
	c_fail: cover property (ent && sbcMode == SbcFailSafe);
	c_sleep: cover property (ent && sbcMode == SbcSleep && can == ModeNormal);
	c_peak: cover property (wr && access.addr == AddrBusB && sbcMode == SbcStop);
endmodule
bind btm_regs btm_regs_asserts btm_regs_asserts_i (.*);
`default_nettype wire

// ---- tb/btm_host_model.sv ----
// Host model issuing one framed register access at a time.
`timescale 1ns/1ps
`default_nettype none
module btm_host_model (
	input  wire logic                 mclk,
	input  wire logic [7:0]           readData,
	output var btm_pkg::btm_access_t  access,
	output var logic                  accessValid,
	output var logic                  chipSelectN
);
	import btm_pkg::*;
	initial begin
		access = '0;
		accessValid = 1'b0;
		chipSelectN = 1'b1;
	end
	// The frame stays low past the synchroniser so slope bits apply only at its end.
	task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d,
			output logic [7:0] q);
		@(negedge mclk) chipSelectN = 1'b0;
		@(negedge mclk) access = '{w, a, d};
		accessValid = 1'b1;
		@(negedge mclk) access = ~access;
		accessValid = 1'b0;
		repeat (6 + $urandom_range(0, 4)) @(negedge mclk);
		chipSelectN = 1'b1;
		repeat (6) @(negedge mclk);
		q = readData;
	endtask
endmodule
`default_nettype wire

// ---- tb/tb_bus_transceiver_mode_regs.sv ----
// Self-checking bench for the mode register bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin failCount++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb_bus_transceiver_mode_regs;
	import btm_pkg::*;
	logic mclk = 0, resetn = 0, softReset = 0, restart = 0, modeEntry = 0, clkEn = 1;
	logic systemErrorEnable = 0, intGlobal = 0, statusEvent = 0, wakeEvent = 0;
	logic [1:0] restartLinMode = 0, restartCanMode = 0, restartSecondLinMode = 0;
	btm_sbc_mode_t sbcMode = SbcInit;
	btm_access_t access;
	logic accessValid, chipSelectN, spiFail, intReq;
	logic [7:0] readData, q, v;
	btm_xcvr_cfg_t xcvrCfg;
	int failCount = 0, totalChecks = 0, cycles = 0;
	always #4 mclk = ~mclk;
	btm_regs btm_regs_i (.clkEn(clkEn), .*);
	btm_host_model btm_host_model_i (.*);
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		btm_host_model_i.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [6:0] a);
		btm_host_model_i.xfer(1'b0, a, 8'h00, q);
	endtask
	task automatic enter(input btm_sbc_mode_t m);
		sbcMode = m;
		modeEntry = 1'b1;
		@(negedge mclk) modeEntry = 1'b0;
	endtask
	function automatic logic [1:0] expCan(input logic [1:0] m, input logic slp, se);
		if (slp && (m == ModeRxOnly || (m == ModeNormal && !se)))
			return ModeWake;
		return m;
	endfunction
	task automatic completeRun();
		$display("checks %0d failures %0d", totalChecks, failCount);
		if (failCount == 0 && totalChecks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			failCount++;
			completeRun();
		end
	end
	initial begin
		void'($urandom(32'h5c88));
		repeat (8) @(negedge mclk);
		resetn = 1'b1;
		rd(AddrBusA); `CHK(q, ResetBusA)
		rd(AddrBusB); `CHK(q, ResetBusB)
		rd(7'h40 | 7'($urandom_range(0, 63))); `CHK(q, 8'h00)
		v = 8'($urandom);
		wr(AddrBusB, v);
		rd(AddrBusB); `CHK(q, v & MaskBusB)
		v = {2'b11, 6'($urandom)};
		wr(AddrBusA, v);
		`CHK(xcvrCfg[10:8], v[7:5])
		rd(AddrBusA); `CHK(q, v)
		for (int i = 0; i < 16; i++) begin
			sbcMode = SbcNormal;
			systemErrorEnable = i[3];
			v = {6'($urandom), 2'(i)};
			wr(AddrBusA, v);
			enter(i[2] ? SbcSleep : SbcStop);
			rd(AddrBusA);
			if (i[2] || i[1:0] != 2'h3)
				`CHK(q[1:0], expCan(v[1:0], i[2], i[3]))
			`CHK(q[2], v[2])
		end
		sbcMode = SbcNormal;
		wr(AddrBusB, 8'h21);
		sbcMode = SbcStop;
		wr(AddrBusB, 8'h02);
		rd(AddrBusB); `CHK({q, spiFail}, {8'h22, 1'b0})
		rd(AddrBusA);
		v = q;
		enter(SbcFailSafe);
		rd(AddrBusA); `CHK(q, {v[7:5], FailSafeLow})
		rd(AddrBusB); `CHK(q[1:0], ModeWake)
		{restartLinMode, restartCanMode, restartSecondLinMode} = 6'($urandom);
		restart = 1'b1;
		@(negedge mclk) restart = 1'b0;
		rd(AddrBusA); `CHK(q[7:5], v[7:5])
		v = q;
		// A soft reset while the clock enable is low must leave all state frozen.
		clkEn = 1'b0;
		softReset = 1'b1;
		repeat (3) @(negedge mclk);
		softReset = 1'b0;
		clkEn = 1'b1;
		rd(AddrBusA); `CHK(q, v)
		for (int i = 0; i < 24; i++) begin
			{intGlobal, statusEvent, wakeEvent} = 3'($urandom);
			@(negedge mclk) `CHK(intReq, wakeEvent | intGlobal & statusEvent)
		end
		{intGlobal, statusEvent, wakeEvent} = 3'h0;
		softReset = 1'b1;
		@(negedge mclk) softReset = 1'b0;
		rd(AddrBusA); `CHK(q, ResetBusA)
		completeRun();
	end
endmodule
`default_nettype wire
